// ==== core/pwd_decoder.sv ====
// planar write instruction decoder with its instruction word fifo
`timescale 1ns/1ps

module pwd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("pwd_fifo: depth must be a power of two of at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    assign o_valid = wr_ptr_reg != rd_ptr_reg;
    assign o_ready = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                     || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule : pwd_fifo

module pwd_decoder
    import pwd_pkg::*;
#(
    parameter int  FIFO_DEPTH    = 8,
    parameter bit  PLANAR_CAPABLE = 1'b1
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_planar_mode,
    input  wire logic        i_word_valid,
    input  wire logic [31:0] i_word,
    output logic             o_word_ready,
    output logic             o_busy,
    output logic             o_unsupported,
    output logic             o_xfer_valid,
    output pwd_xfer_t        o_xfer,
    input  wire logic        i_xfer_ready,
    output logic             o_irq,
    output logic             o_status_apply,
    output logic [3:0]       o_program_status_bits
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("pwd_decoder: fifo depth too small");
        end
    end

    logic        q_valid;
    logic [31:0] q_word;
    logic        q_ready;
    logic        take;
    logic [3:0]  q_opc;
    logic [2:0]  q_need;
    logic        accept_new;

    pwd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_valid (i_word_valid),
        .i_data  (i_word),
        .o_ready (o_word_ready),
        .o_valid (q_valid),
        .o_data  (q_word),
        .i_ready (q_ready)
    );

    pwd_state_t  state_reg;
    logic [2:0]  idx_reg;
    logic [2:0]  need_reg;
    logic [31:0] words_reg [5];
    logic [1:0]  plane_reg;
    logic [3:0]  opc_reg;
    logic [31:0] words_view [5];

    // stored words with the one taken this cycle in ST_FETCH already in place
    always_comb begin
        words_view = words_reg;
        if (take && state_reg == ST_FETCH) begin
            words_view[idx_reg] = q_word;
        end
    end

    assign q_opc  = q_word[OPC_MSB:OPC_LSB];
    // planar writes only when this instance supports them and stream is planar
    assign q_need = (PLANAR_CAPABLE && i_planar_mode)
                    ? pwd_words(q_opc) : WORDS_NONE; // RQ13 RQ14
    assign q_ready = (state_reg == ST_IDLE) || (state_reg == ST_FETCH);
    assign take    = q_valid && q_ready;
    assign accept_new = take && (state_reg == ST_IDLE) && (q_need != '0);
    assign o_busy  = state_reg != ST_IDLE;
    assign o_xfer_valid = state_reg == ST_ISSUE;
    assign opc_reg = words_reg[0][OPC_MSB:OPC_LSB]; // RQ2

    // per-plane request built from the stored words; bit 25 of the first word never looked at
    function automatic pwd_xfer_t build(input logic [1:0] p); // RQ15
        pwd_xfer_t x;
        logic      three;
        x = '0;
        three = words_view[0][OPC_MSB:OPC_LSB] == OPC_THREE_PLANE;
        x.plane   = p;
        x.byte_en = words_view[0][BE_MSB:BE_LSB]; // RQ2
        x.start_of_line_flag = words_view[0][LINE_START_BIT];
        x.end_of_line_flag   = words_view[0][LINE_END_BIT];
        unique case (p)
            PLANE_Y: begin
                x.count = words_view[0][CNT_MSB:CNT_LSB]; // RQ2
                x.addr  = words_view[2]; // RQ5 RQ9
            end
            PLANE_CB: begin
                x.count   = words_view[1][CNT_MSB:CNT_LSB]; // RQ3 RQ12
                x.addr    = three ? words_view[3] : '0; // RQ6
                x.discard = !three; // RQ10
            end
            default: begin
                x.count   = words_view[1][CNT3_MSB:CNT3_LSB]; // RQ4 RQ12
                x.addr    = three ? words_view[4] : '0; // RQ7
                x.discard = !three; // RQ10
            end
        endcase
        return x;
    endfunction : build

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            idx_reg   <= '0;
            need_reg  <= '0;
            plane_reg <= PLANE_Y;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept_new) begin
                        need_reg  <= q_need; // RQ1 RQ9
                        idx_reg   <= 3'h1;
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (take) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == need_reg - 3'h1) begin
                            state_reg <= ST_ISSUE; // RQ1
                            plane_reg <= PLANE_Y;
                        end
                    end
                end
                ST_ISSUE: begin
                    if (i_xfer_ready) begin
                        if (plane_reg == PLANE_CR) begin
                            state_reg <= ST_DONE; // RQ8
                        end else begin
                            plane_reg <= plane_reg + 2'h1;
                        end
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (accept_new) begin
            words_reg[0] <= q_word;
        end else if (take && state_reg == ST_FETCH) begin
            words_reg[idx_reg] <= q_word;
        end
    end

    // request register: loaded when fetch ends and after each accepted plane
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_xfer <= '0;
        end else if (state_reg == ST_FETCH && take
                     && idx_reg == need_reg - 3'h1) begin
            // luma request must be whole in the first cycle valid is up
            o_xfer <= build(PLANE_Y);
        end else if (state_reg == ST_ISSUE) begin
            o_xfer <= build(i_xfer_ready ? plane_reg + 2'h1 : plane_reg);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_unsupported <= 1'b0;
        end else begin
            o_unsupported <= take && state_reg == ST_IDLE && q_need == '0;
        end
    end

    // completion: irq and status bits take effect together; set beats reset
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq                 <= 1'b0;
            o_status_apply        <= 1'b0;
            o_program_status_bits <= STATUS_RESET;
        end else begin
            o_irq          <= state_reg == ST_DONE && words_reg[0][IRQ_BIT];
            o_status_apply <= state_reg == ST_DONE; // RQ16
            if (state_reg == ST_DONE) begin
                o_program_status_bits <= (o_program_status_bits
                    & ~words_reg[0][RST_MSB:RST_LSB])
                    | words_reg[0][SET_MSB:SET_LSB]; // RQ16
            end
        end
    end

    sequence s_plane_acc(logic [1:0] p);
        o_xfer_valid && i_xfer_ready && plane_reg == p;
    endsequence

    sequence s_done_step;
        state_reg == ST_DONE ##1 state_reg == ST_IDLE;
    endsequence

    fetch_count_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ1
        $rose(state_reg == ST_ISSUE) |->
        $past(idx_reg) == pwd_words(opc_reg) - 3'h1)
        else $error("wrong number of words fetched");
    luma_req_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ5
        o_xfer_valid && o_xfer.plane == PLANE_Y |->
        o_xfer.addr == words_reg[2]
        && o_xfer.count == words_reg[0][CNT_MSB:CNT_LSB] && !o_xfer.discard)
        else $error("luma request fields wrong");
    cb_req_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ6
        o_xfer_valid && o_xfer.plane == PLANE_CB
        && opc_reg == OPC_THREE_PLANE |->
        o_xfer.addr == words_reg[3] && !o_xfer.discard
        && o_xfer.count == words_reg[1][CNT_MSB:CNT_LSB])
        else $error("cb request fields wrong");
    cr_req_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ7
        o_xfer_valid && o_xfer.plane == PLANE_CR
        && opc_reg == OPC_THREE_PLANE |->
        o_xfer.addr == words_reg[4]
        && o_xfer.count == words_reg[1][CNT3_MSB:CNT3_LSB])
        else $error("cr request fields wrong");
    chroma_skip_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ10
        o_xfer_valid && o_xfer.plane != PLANE_Y
        && opc_reg == OPC_LUMA_SKIP |-> o_xfer.discard)
        else $error("chroma not discarded");
    plane_walk_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ8
        s_plane_acc(PLANE_CR) |=> s_done_step)
        else $error("completion does not follow last plane");
    plane_sync_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ8
        o_xfer_valid |-> o_xfer.plane == plane_reg)
        else $error("request plane out of step");
    irq_done_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ16
        o_irq |-> $past(state_reg == ST_DONE) && o_status_apply
        && words_reg[0][IRQ_BIT])
        else $error("irq without flagged completion");
    reject_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ13
        take && state_reg == ST_IDLE && !i_planar_mode |=>
        state_reg == ST_IDLE && o_unsupported)
        else $error("planar write taken outside planar mode");
endmodule : pwd_decoder

// ==== shared/pwd_pkg.sv ====
// constants, types and helpers for the planar write instruction decoder
// Contract
// RQ1: opcode 1001 is the three-plane write; fetch five words before executing.
// RQ2: first word: count [11:0], enables, status, irq, line flags, opcode [31:28].
// RQ3: second word [11:0] is the byte count for the Cb FIFO.
// RQ4: second word [27:16] is the byte count for the Cr FIFO.
// RQ5: third word is the luma target byte address.
// RQ6: fourth word is the Cb target byte address.
// RQ7: fifth word is the Cr target byte address.
// RQ8: three-plane write moves every FIFO to its own address with own count.
// RQ9: opcode 1011 is a three-word luma write to the given address.
// RQ10: opcode 1011 discards the requested Cb and Cr bytes.
// RQ11: software uses the luma-only write on lines without stored chroma.
// RQ12: luma-only second word gives discard counts in [11:0] and [27:16].
// RQ13: planar instructions run only while the stream status says planar.
// RQ14: an audio instance rejects planar writes; a video instance runs them.
// RQ15: bit 25 of the first word is ignored.
// RQ16: on completion raise irq if flagged and apply status set/reset bits.
package pwd_pkg;
    localparam logic [3:0] OPC_THREE_PLANE = 4'h9;
    localparam logic [3:0] OPC_LUMA_SKIP   = 4'hb;
    localparam logic [2:0] WORDS_THREE     = 3'h5;
    localparam logic [2:0] WORDS_LUMA      = 3'h3;
    localparam logic [2:0] WORDS_NONE      = 3'h0;
    localparam int CNT_LSB   = 0;
    localparam int CNT_MSB   = 11;
    localparam int CNT3_LSB  = 16;
    localparam int CNT3_MSB  = 27;
    localparam int BE_LSB    = 12;
    localparam int BE_MSB    = 15;
    localparam int SET_LSB   = 16;
    localparam int SET_MSB   = 19;
    localparam int RST_LSB   = 20;
    localparam int RST_MSB   = 23;
    localparam int IRQ_BIT   = 24;
    localparam int LINE_END_BIT   = 26;
    localparam int LINE_START_BIT = 27;
    localparam int OPC_LSB   = 28;
    localparam int OPC_MSB   = 31;
    localparam logic [1:0] PLANE_Y  = 2'h0;
    localparam logic [1:0] PLANE_CB = 2'h1;
    localparam logic [1:0] PLANE_CR = 2'h2;
    localparam logic [3:0] STATUS_RESET = 4'h0;

    typedef struct packed {
        logic [1:0]  plane;
        logic        discard;
        logic [11:0] count;
        logic [31:0] addr;
        logic [3:0]  byte_en;
        logic        start_of_line_flag;
        logic        end_of_line_flag;
    } pwd_xfer_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ISSUE, ST_DONE} pwd_state_t;

    // words an opcode needs; zero means not a planar write
    function automatic logic [2:0] pwd_words(input logic [3:0] opc);
        if (opc == OPC_THREE_PLANE) begin
            return WORDS_THREE;
        end
        if (opc == OPC_LUMA_SKIP) begin
            return WORDS_LUMA;
        end
        return WORDS_NONE;
    endfunction : pwd_words
endpackage : pwd_pkg

// ==== verif/pwd_decoder_tb.sv ====
// self-checking bench for the planar write instruction decoder
`timescale 1ns/1ps

module pwd_decoder_tb;
    import pwd_pkg::*;
    logic        i_clk, i_reset, i_planar_mode, i_word_valid;
    logic [31:0] i_word;
    logic        o_word_ready, o_busy, o_unsupported, o_xfer_valid;
    logic        i_xfer_ready, o_irq, o_status_apply, slow, hold;
    logic        uns2, xv2;
    logic [3:0]  o_program_status_bits;
    pwd_xfer_t   o_xfer;
    int          n_fail, total_checks, n_irq, n_apply, n_uns, n_uns2, n_xv2;

    pwd_decoder uut (.i_clk(i_clk), .i_reset(i_reset),
        .i_planar_mode(i_planar_mode), .i_word_valid(i_word_valid),
        .i_word(i_word), .o_word_ready(o_word_ready), .o_busy(o_busy),
        .o_unsupported(o_unsupported), .o_xfer_valid(o_xfer_valid),
        .o_xfer(o_xfer), .i_xfer_ready(i_xfer_ready), .o_irq(o_irq),
        .o_status_apply(o_status_apply),
        .o_program_status_bits(o_program_status_bits));
    // audio flavour sees the same words but must run none of them
    pwd_decoder #(.PLANAR_CAPABLE(1'b0)) uut2 (.i_clk(i_clk),
        .i_reset(i_reset), .i_planar_mode(i_planar_mode),
        .i_word_valid(i_word_valid), .i_word(i_word), .o_word_ready(),
        .o_busy(), .o_unsupported(uns2), .o_xfer_valid(xv2), .o_xfer(),
        .i_xfer_ready(1'b1), .o_irq(), .o_status_apply(),
        .o_program_status_bits());
    pwd_sink_model m (.i_clk(i_clk), .i_reset(i_reset),
        .i_valid(o_xfer_valid), .i_xfer(o_xfer), .i_slow(slow),
        .i_hold(hold), .o_ready(i_xfer_ready));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        n_irq   += (o_irq === 1'b1);
        n_apply += (o_status_apply === 1'b1);
        n_uns   += (o_unsupported === 1'b1);
        n_uns2  += (uns2 === 1'b1);
        n_xv2   += (xv2 === 1'b1);
    end

    task chk(input string nm, input logic [52:0] e, input logic [52:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task push(input logic [31:0] w);
        int k;
        k = 0;
        i_word_valid <= 1'b1;
        i_word       <= w;
        do begin
            @(negedge i_clk);
            k++;
        end while (o_word_ready !== 1'b1 && k < 400);
        if (o_word_ready !== 1'b1) begin
            n_fail++;
        end
        @(posedge i_clk);
    endtask : push

    task put_three(input logic [31:0] w0, w1, a0, a1, a2);
        push(w0);
        push(w1);
        push(a0);
        push(a1);
        push(a2);
    endtask : put_three

    task put_luma(input logic [31:0] w0, w1, a0);
        push(w0);
        push(w1);
        push(a0);
    endtask : put_luma

    task wait_got(input int n);
        int k;
        k = 0;
        i_word_valid <= 1'b0;
        while (m.got.size() < n && k < 400) begin
            @(negedge i_clk);
            k++;
        end
        if (m.got.size() < n) begin
            n_fail++;
        end
        repeat (5) @(posedge i_clk);
    endtask : wait_got

    task chk_planes(input int b, input logic [52:0] e0, e1, e2);
        chk("xfer count", b + 3, m.got.size());
        if (m.got.size() >= b + 3) begin
            chk("y plane", e0, m.got[b]);
            chk("cb plane", e1, {m.got[b+1][52:6], e1[5:0]});
            chk("cr plane", e2, {m.got[b+2][52:6], e2[5:0]});
        end
    endtask : chk_planes

    task t_three;
        m.got.delete();
        put_three(32'h9d05a123, 32'h04560789, 32'h10000000, 32'h20000004,
                  32'h30000008);
        wait_got(3);
        chk_planes(0, {PLANE_Y, 1'b0, 12'h123, 32'h10000000, 4'ha, 2'h3},
            {PLANE_CB, 1'b0, 12'h789, 32'h20000004, 6'h0},
            {PLANE_CR, 1'b0, 12'h456, 32'h30000008, 6'h0});
        chk("irq", 1, n_irq);
        chk("apply", 1, n_apply);
        chk("status", 4'h5, o_program_status_bits);
        chk("busy idle", 0, o_busy);
    endtask : t_three

    // bit 25 set and end of line only: chroma is dropped on this line
    task t_luma;
        slow <= 1'b1;
        m.got.delete();
        put_luma(32'hb642f040, 32'h00200010, 32'h40000000);
        wait_got(3);
        chk_planes(0, {PLANE_Y, 1'b0, 12'h040, 32'h40000000, 4'hf, 2'h1},
            {PLANE_CB, 1'b1, 12'h010, 32'h0, 6'h0},
            {PLANE_CR, 1'b1, 12'h020, 32'h0, 6'h0});
        chk("irq", 1, n_irq);
        chk("status", 4'h3, o_program_status_bits);
    endtask : t_luma

    task t_bad;
        m.got.delete();
        i_planar_mode <= 1'b0;
        push(32'h9d05a123);
        i_word_valid <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk("drop packed", 1, n_uns);
        i_planar_mode <= 1'b1;
        push(32'h1000a010);
        i_word_valid <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk("drop opcode", 2, n_uns);
        chk("no xfer", 0, m.got.size());
    endtask : t_bad

    // stalled far side: words pile up until the fifo refuses
    task t_fill;
        hold <= 1'b1;
        m.got.delete();
        put_three(32'h9005a123, 32'h04560789, 32'h10000000, 32'h20000004,
                  32'h30000008);
        put_three(32'h9005a123, 32'h04560789, 32'h1, 32'h2, 32'h3);
        put_luma(32'hb642f040, 32'h00200010, 32'h40000000);
        i_word_valid <= 1'b0;
        @(negedge i_clk);
        chk("fifo full", 0, o_word_ready);
        chk("busy", 1, o_busy);
        @(posedge i_clk);
        hold <= 1'b0;
        wait_got(9);
        chk_planes(6, {PLANE_Y, 1'b0, 12'h040, 32'h40000000, 4'hf, 2'h1},
            {PLANE_CB, 1'b1, 12'h010, 32'h0, 6'h0},
            {PLANE_CR, 1'b1, 12'h020, 32'h0, 6'h0});
        chk("apply", 5, n_apply);
        chk("status", 4'h3, o_program_status_bits);
        chk("audio runs", 0, n_xv2);
        chk("audio drops", 1, n_uns2 != 0);
    endtask : t_fill

    task summarize;
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    initial begin
        i_reset       = 1'b1;
        i_planar_mode = 1'b1;
        i_word_valid  = 1'b0;
        i_word        = 32'h0;
        slow          = 1'b0;
        hold          = 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        chk("status init", 4'h0, o_program_status_bits);
        t_three();
        t_luma();
        t_bad();
        t_fill();
        summarize();
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        n_fail++;
        summarize();
    end
endmodule : pwd_decoder_tb

// ==== verif/pwd_sink_model.sv ====
// far side model: bus initiator taking plane requests
`timescale 1ns/1ps

module pwd_sink_model
    import pwd_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_reset,
    input  wire logic      i_valid,
    input  wire pwd_xfer_t i_xfer,
    input  wire logic      i_slow,
    input  wire logic      i_hold,
    output logic           o_ready
);
    pwd_xfer_t got[$];

    // registered ready; slow mode leaves a gap after each accept
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= i_valid & ~i_hold & ~(i_slow & o_ready);
        end
    end

    always @(posedge i_clk) begin
        if (!i_reset && i_valid && o_ready) begin
            got.push_back(i_xfer);
        end
    end
endmodule : pwd_sink_model
